//--- dv/spec_far_model.sv
// far-side model: printer, converter and external pins
`timescale 1ns/1ps
module spec_far_model (
  input  wire logic       CLK,
  input  wire logic       RESET_N,
  input  wire logic       PRINTER_STROBE,
  output logic            PRINTER_BUSY_IN,
  input  wire logic [3:0] ADC_CHANNEL,
  output logic [9:0]      ADC_DATA_IN,
  input  wire logic [4:0] EXT_IO_OUT,
  input  wire logic [4:0] EXT_IO_OE,
  output logic [4:0]      EXT_IO_IN
);
  logic [3:0] busy_ff;
  // printer stays busy a few cycles after each strobe
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) busy_ff <= 4'h0;
    else busy_ff <= PRINTER_STROBE ? 4'hF : busy_ff >> 1;
  end
  assign PRINTER_BUSY_IN = busy_ff[0];
  assign ADC_DATA_IN = {ADC_CHANNEL, 6'h15};
  assign EXT_IO_IN = (EXT_IO_OUT & EXT_IO_OE) | (5'h0A & ~EXT_IO_OE);
endmodule

//--- dv/tb_top.sv
// self-checking bench for the spectrometer control ports
`timescale 1ns/1ps
module tb_top;
  import spec_ctrl_pkg::*;
  localparam int CONV = 5;
  logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic [15:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_d;
  logic [3:0] wstrb, chan, ch;
  logic awready, wready, bvalid, arready, rvalid, nmi, tone, lfa, pstb, busy;
  logic fil_irq, trip_irq, gate, rf, emis, trip;
  logic [1:0] bresp, rresp, rd_r, b_r;
  spect_ctrl_type sctl;
  spare_type spare;
  logic [7:0] pa_out, pa_oe, pdata;
  logic [4:0] ex_in, ex_out, ex_oe;
  logic [9:0] adc;
  logic [11:0] mass;
  logic tone_q;
  logic [7:0] gv [3] = '{8'h60, 8'h61, 8'h62};
  int mismatches, checks_done, n_nmi, n_stb, n_gate, n_tog;
  spec_ctrl_ports #(.TICK_CYCLES_P(20), .STROBE_CYCLES_P(10), .CONV_CYCLES_P(CONV),
    .TONE_HALF_CYCLES_P(4), .BEEP_CYCLES_P(30)) u_spec_ctrl_ports (
    .CLK(clk), .RESET_N(rst_n), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .NMI_TICK(nmi), .AUDIO_TONE(tone), .SPECT_CTRL(sctl), .LARGE_FEEDBACK_ACTIVE(lfa),
    .SPARE_OUT(spare), .PORTA_IN(pa_out), .PORTA_OUT(pa_out), .PORTA_OE(pa_oe),
    .PRINTER_DATA_BITS(pdata), .PRINTER_STROBE(pstb), .PRINTER_BUSY_IN(busy),
    .EXT_IO_IN(ex_in), .EXT_IO_OUT(ex_out), .EXT_IO_OE(ex_oe), .RF_MONITOR_IN(rf),
    .EMISSION_OK_IN(emis), .SUPPLY_TRIP_IN(trip), .FILAMENT_IRQ(fil_irq),
    .TRIP_IRQ_LINE(trip_irq), .ADC_CHANNEL(chan), .CONVERSION_GATE(gate),
    .ADC_DATA_IN(adc), .MASS_DAC(mass));
  spec_far_model u_spec_far_model (.CLK(clk), .RESET_N(rst_n), .PRINTER_STROBE(pstb),
    .PRINTER_BUSY_IN(busy), .ADC_CHANNEL(chan), .ADC_DATA_IN(adc),
    .EXT_IO_OUT(ex_out), .EXT_IO_OE(ex_oe), .EXT_IO_IN(ex_in));
  always #2 clk = ~clk;
  // event counters sampled mid-cycle where outputs are settled
  always @(negedge clk) begin
    if (nmi === 1'b1) n_nmi++;
    if (pstb === 1'b1) n_stb++;
    if (gate === 1'b1) n_gate++;
    if (tone !== tone_q) n_tog++;
    tone_q = tone;
  end
  task automatic results;
    if (mismatches == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
      mismatches++;
    end
  endtask
  task automatic lost;
    $display("CHECK FAILED %0t bus wait ran out", $time);
    mismatches++;
    results();
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    bit ta, tw, tk;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 50 && !tk; n++) begin
      @(negedge clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tk = bvalid && bready;
      if (tk) b_r = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tk) bready <= 1'b0;
    end
    if (!tk) lost();
  endtask
  task automatic rd(input logic [15:0] a);
    bit ta, tk;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 50 && !tk; n++) begin
      @(negedge clk);
      ta = arvalid && arready;
      tk = rvalid && rready;
      if (tk) rd_d = rdata;
      if (tk) rd_r = rresp;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
      if (tk) rready <= 1'b0;
    end
    if (!tk) lost();
  endtask
  initial begin
    {clk, rst_n, awvalid, wvalid, bready, arvalid, rready, trip} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    {emis, rf} = 2'h3;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    chk(32'(sctl), 32'h60);
    chk(32'(spare), 32'h4);
    rd(SPECT_CTRL_ADDR);
    chk(rd_d, 32'h60);
    for (int i = 0; i < 3; i++) begin
      wr(SPECT_CTRL_ADDR, 32'(gv[i]));
      chk(32'(sctl), 32'(gv[i]));
    end
    wr(SPECT_CTRL_ADDR, 32'h1F);
    chk(32'(sctl), 32'h1E);
    chk(32'(lfa), 32'h1);
    wr(SPECT_CTRL_ADDR, 32'hFF);
    chk(32'(sctl), 32'h7E);
    n_nmi = 0;
    repeat (200) @(posedge clk);
    chk(n_nmi, 10);
    wr(PRN_DATA_ADDR, 32'hA5);
    chk(32'(pdata), 32'hA5);
    n_stb = 0;
    wr(PRN_CTRL_ADDR, 32'h1);
    rd(PRN_CTRL_ADDR);
    chk(rd_d, 32'h6);
    repeat (30) @(posedge clk);
    chk(n_stb, 10);
    emis <= 1'b0;
    repeat (3) @(posedge clk);
    chk(32'(fil_irq), 32'h1);
    rd(EVENT_ADDR);
    chk(rd_d, 32'h1);
    wr(EVENT_ADDR, 32'h1);
    chk(32'(fil_irq), 32'h0);
    trip <= 1'b1;
    rf <= 1'b0;
    repeat (3) @(posedge clk);
    chk(32'(trip_irq), 32'h1);
    rd(EXT_IO_ADDR);
    chk(rd_d, 32'hAA);
    wr(EXT_IO_ADDR, 32'h1F15);
    chk(32'({ex_oe, ex_out}), 32'h3F5);
    for (int i = 0; i < 2; i++) begin
      ch = 4'(3 * i);
      n_gate = 0;
      wr(ADC_CTRL_ADDR, {23'h0, 1'b1, 4'h0, ch});
      repeat (CONV + 4) @(posedge clk);
      chk(n_gate, CONV);
      chk(32'(chan), 32'(ch));
      rd(ADC_CTRL_ADDR);
      chk(rd_d, {22'h0, ch, 6'h15});
    end
    rd(ADC_STAT_ADDR);
    chk(rd_d, 32'h30);
    wr(MASS_DAC_ADDR, 32'hFABC);
    chk(32'(mass), 32'hABC);
    wr(SPARE_ADDR, 32'h3);
    chk(32'(spare), 32'h3);
    wr(PORTA_ADDR, 32'hC300);
    wr(PORTA_DIR_ADDR, 32'h0F);
    chk(32'({pa_oe, pa_out}), 32'h0FC3);
    rd(PORTA_ADDR);
    chk(rd_d, 32'hC3C3);
    rd(16'h80F0);
    chk(32'(rd_r), 32'(RESP_SLVERR));
    wr(16'h80F0, 32'h1);
    chk(32'(b_r), 32'(RESP_SLVERR));
    wr(TONE_ADDR, 32'h1);
    n_tog = 0;
    repeat (40) @(posedge clk);
    chk(n_tog, 10);
    wr(TONE_ADDR, 32'h2);
    rd(TONE_ADDR);
    chk(rd_d, 32'h2);
    repeat (50) @(posedge clk);
    chk(32'(tone), 32'h0);
    results();
  end
endmodule

//--- hdl/spec_ctrl_pkg.sv
// constants, carriers and state layout for the spectrometer control ports
package spec_ctrl_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam logic [15:0] ADC_CTRL_ADDR  = 16'h8000;
  localparam logic [15:0] ADC_STAT_ADDR  = 16'h8004;
  localparam logic [15:0] MASS_DAC_ADDR  = 16'h8050;
  localparam logic [15:0] PRN_DATA_ADDR  = 16'h8060;
  localparam logic [15:0] PRN_CTRL_ADDR  = 16'h8064;
  localparam logic [15:0] EXT_IO_ADDR    = 16'h8068;
  localparam logic [15:0] EVENT_ADDR     = 16'h806C;
  localparam logic [15:0] PORTA_ADDR     = 16'h8080;
  localparam logic [15:0] SPECT_CTRL_ADDR = 16'h8084;
  localparam logic [15:0] PORTA_DIR_ADDR = 16'h8088;
  localparam logic [15:0] TONE_ADDR      = 16'h808C;
  localparam logic [15:0] SPARE_ADDR     = 16'h8090;
  localparam int TONE_CONT_BIT = 0;
  localparam int TONE_BEEP_BIT = 1;
  localparam int PRN_GO_BIT    = 0;
  localparam int PRN_BUSY_BIT  = 1;
  localparam int PRN_STRB_BIT  = 2;
  localparam int EV_FIL_BIT    = 0;
  localparam int EV_TRIP_BIT   = 1;
  localparam int ADC_START_BIT = 8;
  localparam int ADC_BUSY_BIT  = 0;
  localparam int EXT_DIR_LSB   = 8;
  localparam int ST_RF_BIT     = 5;
  localparam int ST_EMIS_BIT   = 6;
  localparam int ST_TRIP_BIT   = 7;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int CLK_MHZ      = 250;
  localparam int TICK_US      = 300;
  localparam int TICK_CYCLES  = TICK_US * CLK_MHZ;
  localparam int STROBE_NS    = 1000;
  localparam int STROBE_CYCLES = (STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int CONV_US      = 10;
  localparam int CONV_CYCLES  = CONV_US * CLK_MHZ;
  localparam int TONE_HALF_US = 250;
  localparam int TONE_HALF_CYCLES = TONE_HALF_US * CLK_MHZ;
  localparam int BEEP_MS      = 50;
  localparam int BEEP_CYCLES  = BEEP_MS * 1000 * CLK_MHZ;
  localparam int TICK_W = 17;
  localparam int TONE_W = 16;
  localparam int BEEP_W = 24;
  localparam int STRB_W = 8;
  localparam int CONV_W = 12;
  typedef struct packed {
    logic port_b_top_line;
    logic ion_beam_off_n;
    logic multiplier_supply_n;
    logic total_pressure_gain;
    logic rod_voltage_off;
    logic feedback_resistor_select;
    logic gain_x100_select;
    logic gain_x10_select;
  } spect_ctrl_type;
  typedef struct packed {
    logic source_normal_not_degas;
    logic filament_relay_select;
    logic filament_on;
  } spare_type;
  localparam spect_ctrl_type SPECT_CTRL_RESET = 8'h60;
  localparam spare_type      SPARE_RESET      = 3'h4;
  typedef enum logic [1:0] {
    CONV_IDLE  = 2'h0,
    CONV_RUN   = 2'h1,
    CONV_LATCH = 2'h3
  } conv_state_type;
  typedef struct packed {
    logic                aw_ok;
    logic [ADDR_W-1:0]   aw_addr;
    logic                w_ok;
    logic [15:0]         w_data;
    logic [1:0]          w_strb;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                rvalid;
    logic [1:0]          rresp;
    logic [15:0]         rdata;
    logic [TICK_W-1:0]   tick_cnt;
    logic                nmi;
    logic                tone_cont;
    logic [BEEP_W-1:0]   beep_cnt;
    logic [TONE_W-1:0]   tone_cnt;
    logic                tone;
    spect_ctrl_type      ctrl;
    spare_type           spare;
    logic [7:0]          porta_out;
    logic [7:0]          porta_dir;
    logic [7:0]          prn_data;
    logic [STRB_W-1:0]   strobe_cnt;
    logic [4:0]          ext_out;
    logic [4:0]          ext_dir;
    logic                emis_prev;
    logic                trip_prev;
    logic                fil_flag;
    logic                trip_flag;
    conv_state_type      conv;
    logic [CONV_W-1:0]   conv_cnt;
    logic [3:0]          channel;
    logic [9:0]          adc_result;
    logic [11:0]         mass;
  } state_type;
endpackage

//--- hdl/spec_ctrl_ports.sv
// spectrometer control ports: tick, tone, control bits, printer, events, converter
// Behaviour
// (R01) periodic non-maskable tick every 300 us
// (R02) tone output: continuous mode plus key beeps
// (R03) control port eight outputs, top unused
// (R04) two gain bits select 1, 10, 100
// (R05) both gain bits never high together
// (R06) feedback relay bit gives six decades
// (R07) rod-off and total-pressure gain bits
// (R08) active-low multiplier supply enable bit
// (R09) active-low ion beam suppress bit
// (R10) printer port carries eight data bits
// (R11) printer strobe out, busy sampled in
// (R12) five general lines to external connector
// (R13) low RF monitor line flags fault
// (R14) filament failure falling edge raises interrupt
// (R15) supply trip raises separate interrupt
// (R16) filament on and filament relay outputs
// (R17) source mode high normal, low degas
// (R18) 10-bit converter, sixteen channels, channel zero amplifier
// (R19) channels for rails and external signals
// (R20) conversion gate high throughout conversion
// (R21) large feedback selection switches extra smoothing
// (R22) 12-bit mass scale program value
// (R23) control logic runs from one system clock
// (R24) interface units at 8060 and 8080 blocks
// (R25) converter decoded at 8000 block
// (R26) reset gives safe directions and levels
// (R27) tick counter reloads itself each expiry
`timescale 1ns/1ps
module spec_ctrl_ports #(
  parameter int TICK_CYCLES_P      = spec_ctrl_pkg::TICK_CYCLES,
  parameter int STROBE_CYCLES_P    = spec_ctrl_pkg::STROBE_CYCLES,
  parameter int CONV_CYCLES_P      = spec_ctrl_pkg::CONV_CYCLES,
  parameter int TONE_HALF_CYCLES_P = spec_ctrl_pkg::TONE_HALF_CYCLES,
  parameter int BEEP_CYCLES_P      = spec_ctrl_pkg::BEEP_CYCLES
) (
  input  wire logic                              CLK,
  input  wire logic                              RESET_N,
  input  wire logic [spec_ctrl_pkg::ADDR_W-1:0]  S_AXI_AWADDR,
  input  wire logic                              S_AXI_AWVALID,
  output logic                                   S_AXI_AWREADY,
  input  wire logic [spec_ctrl_pkg::DATA_W-1:0]  S_AXI_WDATA,
  input  wire logic [3:0]                        S_AXI_WSTRB,
  input  wire logic                              S_AXI_WVALID,
  output logic                                   S_AXI_WREADY,
  output logic [1:0]                             S_AXI_BRESP,
  output logic                                   S_AXI_BVALID,
  input  wire logic                              S_AXI_BREADY,
  input  wire logic [spec_ctrl_pkg::ADDR_W-1:0]  S_AXI_ARADDR,
  input  wire logic                              S_AXI_ARVALID,
  output logic                                   S_AXI_ARREADY,
  output logic [spec_ctrl_pkg::DATA_W-1:0]       S_AXI_RDATA,
  output logic [1:0]                             S_AXI_RRESP,
  output logic                                   S_AXI_RVALID,
  input  wire logic                              S_AXI_RREADY,
  output logic                                   NMI_TICK,
  output logic                                   AUDIO_TONE,
  output spec_ctrl_pkg::spect_ctrl_type          SPECT_CTRL,
  output logic                                   LARGE_FEEDBACK_ACTIVE,
  output spec_ctrl_pkg::spare_type               SPARE_OUT,
  input  wire logic [7:0]                        PORTA_IN,
  output logic [7:0]                             PORTA_OUT,
  output logic [7:0]                             PORTA_OE,
  output logic [7:0]                             PRINTER_DATA_BITS,
  output logic                                   PRINTER_STROBE,
  input  wire logic                              PRINTER_BUSY_IN,
  input  wire logic [4:0]                        EXT_IO_IN,
  output logic [4:0]                             EXT_IO_OUT,
  output logic [4:0]                             EXT_IO_OE,
  input  wire logic                              RF_MONITOR_IN,
  input  wire logic                              EMISSION_OK_IN,
  input  wire logic                              SUPPLY_TRIP_IN,
  output logic                                   FILAMENT_IRQ,
  output logic                                   TRIP_IRQ_LINE,
  output logic [3:0]                             ADC_CHANNEL,
  output logic                                   CONVERSION_GATE,
  input  wire logic [9:0]                        ADC_DATA_IN,
  output logic [11:0]                            MASS_DAC
);
  import spec_ctrl_pkg::*;

  localparam logic [TICK_W-1:0] TICK_LAST   = TICK_W'(TICK_CYCLES_P - 1);
  localparam logic [STRB_W-1:0] STROBE_LEN  = STRB_W'(STROBE_CYCLES_P);
  localparam logic [CONV_W-1:0] CONV_LEN    = CONV_W'(CONV_CYCLES_P);
  localparam logic [TONE_W-1:0] TONE_LAST   = TONE_W'(TONE_HALF_CYCLES_P - 1);
  localparam logic [BEEP_W-1:0] BEEP_LEN    = BEEP_W'(BEEP_CYCLES_P);

  state_type st_ff;
  state_type nxt_st;

  logic        wr_go;
  logic        rd_go;
  logic [15:0] rd_val;
  logic        rd_hit;
  logic        wr_hit;
  logic [15:0] wv;
  logic        tone_active;

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] d,
                                        input logic [1:0] s);
    merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  assign S_AXI_AWREADY = !st_ff.aw_ok && !st_ff.bvalid;
  assign S_AXI_WREADY  = !st_ff.w_ok && !st_ff.bvalid;
  assign S_AXI_ARREADY = !st_ff.rvalid;
  assign wr_go = st_ff.aw_ok && st_ff.w_ok && !st_ff.bvalid;
  assign rd_go = S_AXI_ARVALID && !st_ff.rvalid;
  assign tone_active = st_ff.tone_cont || (st_ff.beep_cnt != '0);

  // read decode, registers reached by AXI are word aligned
  always_comb begin
    rd_val = '0;
    rd_hit = 1'b1;
    case (S_AXI_ARADDR)
      ADC_CTRL_ADDR:   rd_val = {6'h00, st_ff.adc_result}; // R25
      ADC_STAT_ADDR:   rd_val = {8'h00, st_ff.channel, 3'h0, 1'(st_ff.conv != CONV_IDLE)}; // R25
      MASS_DAC_ADDR:   rd_val = {4'h0, st_ff.mass};
      PRN_DATA_ADDR:   rd_val = {8'h00, st_ff.prn_data}; // R24
      PRN_CTRL_ADDR:   rd_val = {13'h0000, 1'(st_ff.strobe_cnt != '0), PRINTER_BUSY_IN, 1'b0}; // R11
      EXT_IO_ADDR:     rd_val = {3'h0, st_ff.ext_dir, SUPPLY_TRIP_IN, EMISSION_OK_IN,
                                 !RF_MONITOR_IN, EXT_IO_IN}; // R13
      EVENT_ADDR:      rd_val = {14'h0000, st_ff.trip_flag, st_ff.fil_flag};
      PORTA_ADDR:      rd_val = {st_ff.porta_out, PORTA_IN}; // R24
      SPECT_CTRL_ADDR: rd_val = {8'h00, st_ff.ctrl};
      PORTA_DIR_ADDR:  rd_val = {8'h00, st_ff.porta_dir};
      TONE_ADDR:       rd_val = {14'h0000, 1'(st_ff.beep_cnt != '0), st_ff.tone_cont};
      SPARE_ADDR:      rd_val = {13'h0000, st_ff.spare};
      default:         rd_hit = 1'b0;
    endcase
  end

  always_comb begin
    nxt_st = st_ff;
    wr_hit = 1'b1;
    wv = '0;
    // bus channels
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      nxt_st.aw_ok   = 1'b1;
      nxt_st.aw_addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      nxt_st.w_ok   = 1'b1;
      nxt_st.w_data = S_AXI_WDATA[15:0];
      nxt_st.w_strb = S_AXI_WSTRB[1:0];
    end
    if (st_ff.bvalid && S_AXI_BREADY) begin
      nxt_st.bvalid = 1'b0;
    end
    if (st_ff.rvalid && S_AXI_RREADY) begin
      nxt_st.rvalid = 1'b0;
    end
    if (rd_go) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata  = rd_val;
      nxt_st.rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    // periodic tick, reloads itself
    if (st_ff.tick_cnt == '0) begin
      nxt_st.tick_cnt = TICK_LAST; // R01 R27
    end else begin
      nxt_st.tick_cnt = st_ff.tick_cnt - 1'b1;
    end
    nxt_st.nmi = (st_ff.tick_cnt == '0); // R01
    // tone generator
    if (st_ff.beep_cnt != '0) begin
      nxt_st.beep_cnt = st_ff.beep_cnt - 1'b1;
    end
    if (!tone_active) begin
      nxt_st.tone     = 1'b0; // R02
      nxt_st.tone_cnt = TONE_LAST;
    end else if (st_ff.tone_cnt == '0) begin
      nxt_st.tone     = !st_ff.tone; // R02
      nxt_st.tone_cnt = TONE_LAST;
    end else begin
      nxt_st.tone_cnt = st_ff.tone_cnt - 1'b1;
    end
    // printer strobe width
    if (st_ff.strobe_cnt != '0) begin
      nxt_st.strobe_cnt = st_ff.strobe_cnt - 1'b1;
    end
    // converter sequence
    case (st_ff.conv)
      CONV_IDLE: begin
      end
      CONV_RUN: begin
        if (st_ff.conv_cnt <= CONV_W'(1)) begin
          nxt_st.conv = CONV_LATCH;
        end else begin
          nxt_st.conv_cnt = st_ff.conv_cnt - 1'b1;
        end
      end
      CONV_LATCH: begin
        nxt_st.adc_result = ADC_DATA_IN; // R18
        nxt_st.conv       = CONV_IDLE;
      end
      default: nxt_st.conv = CONV_IDLE;
    endcase
    // event flags: hardware set wins over software clear
    nxt_st.emis_prev = EMISSION_OK_IN;
    nxt_st.trip_prev = SUPPLY_TRIP_IN;
    // register writes
    if (wr_go) begin
      nxt_st.aw_ok  = 1'b0;
      nxt_st.w_ok   = 1'b0;
      nxt_st.bvalid = 1'b1;
      case (st_ff.aw_addr)
        ADC_CTRL_ADDR: begin
          wv = merge({12'h000, st_ff.channel}, st_ff.w_data, st_ff.w_strb);
          if (st_ff.conv == CONV_IDLE) begin
            nxt_st.channel = wv[3:0]; // R18 R19
            if (wv[ADC_START_BIT]) begin
              nxt_st.conv     = CONV_RUN;
              nxt_st.conv_cnt = CONV_LEN;
            end
          end
        end
        MASS_DAC_ADDR: begin
          wv = merge({4'h0, st_ff.mass}, st_ff.w_data, st_ff.w_strb);
          nxt_st.mass = wv[11:0]; // R22
        end
        PRN_DATA_ADDR: begin
          wv = merge({8'h00, st_ff.prn_data}, st_ff.w_data, st_ff.w_strb);
          nxt_st.prn_data = wv[7:0]; // R10
        end
        PRN_CTRL_ADDR: begin
          if (st_ff.w_strb[0] && st_ff.w_data[PRN_GO_BIT] && st_ff.strobe_cnt == '0) begin
            nxt_st.strobe_cnt = STROBE_LEN; // R11
          end
        end
        EXT_IO_ADDR: begin
          wv = merge({3'h0, st_ff.ext_dir, 3'h0, st_ff.ext_out}, st_ff.w_data, st_ff.w_strb);
          nxt_st.ext_out = wv[4:0]; // R12
          nxt_st.ext_dir = wv[EXT_DIR_LSB +: 5];
        end
        EVENT_ADDR: begin
          if (st_ff.w_strb[0]) begin
            nxt_st.fil_flag  = st_ff.fil_flag && !st_ff.w_data[EV_FIL_BIT];
            nxt_st.trip_flag = st_ff.trip_flag && !st_ff.w_data[EV_TRIP_BIT];
          end
        end
        PORTA_ADDR: begin
          if (st_ff.w_strb[1]) begin
            nxt_st.porta_out = st_ff.w_data[15:8];
          end
        end
        SPECT_CTRL_ADDR: begin
          if (st_ff.w_strb[0]) begin
            nxt_st.ctrl = st_ff.w_data[7:0]; // R03 R06 R07 R08 R09
            nxt_st.ctrl.port_b_top_line = 1'b0; // R03
            if (st_ff.w_data[1] && st_ff.w_data[0]) begin
              nxt_st.ctrl.gain_x10_select  = st_ff.ctrl.gain_x10_select; // R05
              nxt_st.ctrl.gain_x100_select = st_ff.ctrl.gain_x100_select; // R05
            end
          end
        end
        PORTA_DIR_ADDR: begin
          wv = merge({8'h00, st_ff.porta_dir}, st_ff.w_data, st_ff.w_strb);
          nxt_st.porta_dir = wv[7:0];
        end
        TONE_ADDR: begin
          if (st_ff.w_strb[0]) begin
            nxt_st.tone_cont = st_ff.w_data[TONE_CONT_BIT]; // R02
            if (st_ff.w_data[TONE_BEEP_BIT]) begin
              nxt_st.beep_cnt = BEEP_LEN; // R02
            end
          end
        end
        SPARE_ADDR: begin
          if (st_ff.w_strb[0]) begin
            nxt_st.spare = st_ff.w_data[2:0]; // R16 R17
          end
        end
        default: wr_hit = 1'b0;
      endcase
      nxt_st.bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    if (st_ff.emis_prev && !EMISSION_OK_IN) begin
      nxt_st.fil_flag = 1'b1; // R14
    end
    if (!st_ff.trip_prev && SUPPLY_TRIP_IN) begin
      nxt_st.trip_flag = 1'b1; // R15
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin // R23
    if (!RESET_N) begin
      st_ff          <= '0;
      st_ff.tick_cnt <= TICK_LAST; // R27
      st_ff.ctrl     <= SPECT_CTRL_RESET; // R26
      st_ff.spare    <= SPARE_RESET; // R26 R17
      st_ff.emis_prev <= 1'b1;
      st_ff.tone_cnt <= TONE_LAST;
      st_ff.conv     <= CONV_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign S_AXI_BVALID          = st_ff.bvalid;
  assign S_AXI_BRESP           = st_ff.bresp;
  assign S_AXI_RVALID          = st_ff.rvalid;
  assign S_AXI_RRESP           = st_ff.rresp;
  assign S_AXI_RDATA           = {16'h0000, st_ff.rdata};
  assign NMI_TICK              = st_ff.nmi;
  assign AUDIO_TONE            = st_ff.tone;
  assign SPECT_CTRL            = st_ff.ctrl; // R04 R08 R09
  assign LARGE_FEEDBACK_ACTIVE = st_ff.ctrl.feedback_resistor_select; // R21
  assign SPARE_OUT             = st_ff.spare; // R16 R17
  assign PORTA_OUT             = st_ff.porta_out;
  assign PORTA_OE              = st_ff.porta_dir;
  assign PRINTER_DATA_BITS     = st_ff.prn_data; // R10
  assign PRINTER_STROBE        = (st_ff.strobe_cnt != '0); // R11
  assign EXT_IO_OUT            = st_ff.ext_out;
  assign EXT_IO_OE             = st_ff.ext_dir; // R12
  assign FILAMENT_IRQ          = st_ff.fil_flag; // R14
  assign TRIP_IRQ_LINE         = st_ff.trip_flag; // R15
  assign ADC_CHANNEL           = st_ff.channel;
  assign CONVERSION_GATE       = (st_ff.conv == CONV_RUN); // R20
  assign MASS_DAC              = st_ff.mass; // R22

  // checks
  gain_exclusive_a: assert property (@(posedge CLK) disable iff (!RESET_N) // R05
    !(SPECT_CTRL.gain_x10_select && SPECT_CTRL.gain_x100_select))
    else $error("both gain bits high");
  tick_reload_a: assert property (@(posedge CLK) disable iff (!RESET_N) // R27
    NMI_TICK |-> st_ff.tick_cnt == TICK_LAST)
    else $error("tick counter did not reload");
  tick_single_a: assert property (@(posedge CLK) disable iff (!RESET_N) // R01
    NMI_TICK |=> !NMI_TICK ##1 !NMI_TICK)
    else $error("tick pulse too long");
  gate_hold_a: assert property (@(posedge CLK) disable iff (!RESET_N) // R20
    CONVERSION_GATE && st_ff.conv_cnt > CONV_W'(1) |=> CONVERSION_GATE)
    else $error("conversion gate broke early");
  gate_latch_a: assert property (@(posedge CLK) disable iff (!RESET_N) // R20
    $fell(CONVERSION_GATE) |-> st_ff.conv == CONV_LATCH ##1 st_ff.adc_result == $past(ADC_DATA_IN))
    else $error("gate dropped without latch");
  filament_irq_a: assert property (@(posedge CLK) disable iff (!RESET_N) // R14
    $fell(EMISSION_OK_IN) |=> FILAMENT_IRQ)
    else $error("filament failure not flagged");
  trip_irq_a: assert property (@(posedge CLK) disable iff (!RESET_N) // R15
    $rose(SUPPLY_TRIP_IN) |=> TRIP_IRQ_LINE)
    else $error("supply trip not flagged");
  feedback_tie_a: assert property (@(posedge CLK) disable iff (!RESET_N) // R21
    wr_go && st_ff.aw_addr == SPECT_CTRL_ADDR && st_ff.w_strb[0]
    |=> LARGE_FEEDBACK_ACTIVE == $past(st_ff.w_data[2]))
    else $error("smoothing select not tied to feedback bit");
  // the bus answers one cycle after a request is complete
  rd_answer_a: assert property (@(posedge CLK) disable iff (!RESET_N) // R24
    S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read not answered");
  wr_answer_a: assert property (@(posedge CLK) disable iff (!RESET_N) // R24
    wr_go |=> S_AXI_BVALID)
    else $error("write not answered");
  conv_start_a: assert property (@(posedge CLK) disable iff (!RESET_N) // R20
    wr_go && st_ff.aw_addr == ADC_CTRL_ADDR && wv[ADC_START_BIT]
    && st_ff.conv == CONV_IDLE |=> CONVERSION_GATE)
    else $error("conversion did not start");
  tone_quiet_a: assert property (@(posedge CLK) disable iff (!RESET_N) // R02
    !tone_active |=> !AUDIO_TONE)
    else $error("tone sounding while idle");
  strobe_width_a: assert property (@(posedge CLK) disable iff (!RESET_N) // R11
    $rose(PRINTER_STROBE) |-> PRINTER_STROBE[*8])
    else $error("printer strobe too short");
  top_line_a: assert property (@(posedge CLK) disable iff (!RESET_N) // R03
    !SPECT_CTRL.port_b_top_line)
    else $error("unused control line driven");
  conv_cover_c: cover property (@(posedge CLK) disable iff (!RESET_N)
    $fell(CONVERSION_GATE));
  print_cover_c: cover property (@(posedge CLK) disable iff (!RESET_N)
    $rose(PRINTER_STROBE));
  beep_cover_c: cover property (@(posedge CLK) disable iff (!RESET_N)
    !st_ff.tone_cont && $rose(AUDIO_TONE));
  irq_cover_c: cover property (@(posedge CLK) disable iff (!RESET_N)
    FILAMENT_IRQ && TRIP_IRQ_LINE);
endmodule
